// ==== logic/bcd_adjuster.sv ====
// decimal adjust datapath for the accumulator after an addition
`timescale 1ns/1ns
module bcd_adjuster
    import exec_pkg::*;
(
    input wire logic [7:0] acc_in, // accumulator value to adjust
    input wire logic half_carry, // half-carry flag
    input wire logic carry_in, // carry flag
    output logic [7:0] result, // adjusted byte
    output logic carry_out // new carry flag
);
    logic [4:0] low_sum;
    logic [4:0] high_sum;
    logic low_nibble_adjust_carry;
    logic [4:0] high_base;

    always_comb
    begin
        if ((acc_in[3:0] > BCD_LIMIT) || half_carry)
        begin
            low_sum = {1'b0, acc_in[3:0]} + {1'b0, BCD_CORRECTION};
            low_nibble_adjust_carry = ~half_carry;
        end
        else
        begin
            low_sum = {1'b0, acc_in[3:0]};
            low_nibble_adjust_carry = 1'b0;
        end
        high_base = {1'b0, acc_in[7:4]} + {4'h0, low_nibble_adjust_carry};
        if ((high_base > {1'b0, BCD_LIMIT}) || carry_in)
        begin
            high_sum = high_base + {1'b0, BCD_CORRECTION};
            carry_out = 1'b1;
        end
        else
        begin
            high_sum = high_base;
            carry_out = carry_in;
        end
        result = {high_sum[3:0], low_sum[3:0]};
    end
endmodule

// ==== logic/exec_pkg.sv ====
// shared constants and operation codes for the instruction execution block
package exec_pkg;
    localparam int DATA_W = 8;
    localparam int PC_W = 10;
    localparam int ADDR_W = 6;
    localparam int STACK_DEPTH = 2;
    localparam int CLKS_PER_CYCLE = 4;
    localparam logic [3:0] BCD_LIMIT = 4'h9;
    localparam logic [3:0] BCD_CORRECTION = 4'h6;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [PC_W-1:0] PC_RESET = 10'h000;
    localparam logic [7:0] WDOG_RESET = 8'h00;
    localparam logic [7:0] PRESCALE_RESET = 8'h00;

    typedef enum logic [4:0] {
        OP_IDLE = 5'b00000,
        OP_INVERT_MEM = 5'b00001,
        OP_INVERT_TO_ACC = 5'b00010,
        OP_BCD_ADJUST = 5'b00011,
        OP_MINUS_ONE_MEM = 5'b00100,
        OP_MINUS_ONE_TO_ACC = 5'b00101,
        OP_PLUS_ONE_MEM = 5'b00110,
        OP_PLUS_ONE_TO_ACC = 5'b00111,
        OP_POWER_DOWN = 5'b01000,
        OP_DIRECT_BRANCH = 5'b01001,
        OP_COPY_MEM_TO_ACC = 5'b01010,
        OP_COPY_ACC_TO_MEM = 5'b01011,
        OP_COPY_IMM_TO_ACC = 5'b01100,
        OP_DISJ_MEM_TO_ACC = 5'b01101,
        OP_DISJ_IMM_TO_ACC = 5'b01110,
        OP_DISJUNCTION_TO_MEM = 5'b01111,
        OP_POP_PROGRAM_COUNTER = 5'b10000,
        OP_POP_WITH_CONST = 5'b10001,
        OP_INTERRUPT_EXIT = 5'b10010,
        OP_ROTATE_LEFT_MEM = 5'b10011,
        OP_ROTATE_LEFT_TO_ACC = 5'b10100,
        OP_ROTATE_LEFT_THROUGH_CARRY = 5'b10101,
        OP_ROTATE_LEFT_CARRY_TO_ACC = 5'b10110,
        OP_CALL = 5'b10111,
        OP_CLEAR_WATCHDOG = 5'b11000
    } op_t;

    typedef enum logic [1:0] {
        ST_EXEC = 2'b00,
        ST_WAIT = 2'b01,
        ST_HALTED = 2'b10
    } state_t;
endpackage

// ==== logic/instr_exec.sv ====
// instruction execution core for the complement, adjust, step, move, or, return and left rotate group
`timescale 1ns/1ns

module instr_exec
    import exec_pkg::*;
(
    input wire logic sys_clk, // system clock, 10 MHz
    input wire logic sys_rst, // synchronous reset, active high
    input wire logic instr_valid, // instruction presented, taken when ready
    input wire logic [4:0] instr_op, // operation code, op_t
    input wire logic [ADDR_W-1:0] instr_addr, // data memory address
    input wire logic [7:0] instr_imm, // immediate byte
    input wire logic [PC_W-1:0] instr_target, // branch or call target
    input wire logic wake, // wake-up event leaving power down
    input wire logic wdog_tick, // watchdog prescaler clock tick
    input wire logic mem_wr_en, // external data memory write
    input wire logic [ADDR_W-1:0] mem_wr_addr, // external write address
    input wire logic [7:0] mem_wr_data, // external write data
    input wire logic [ADDR_W-1:0] mem_rd_addr, // external read address
    output logic [7:0] mem_rd_data, // external read data, one cycle later
    output logic instr_ready, // core can take an instruction
    output logic [PC_W-1:0] pc, // program counter
    output logic [7:0] acc, // accumulator
    output logic zero_flag, // zero status flag
    output logic carry_flag, // carry status flag
    output logic half_carry_flag, // half carry status flag
    output logic overflow_flag, // overflow status flag
    output logic power_down_flag, // set on power-down entry
    output logic watchdog_expiry_flag, // set on watchdog overflow
    output logic global_irq_enable, // master interrupt enable
    output logic clock_gated, // system clock gated off in power down
    output logic [7:0] watchdog_counter // watchdog count
);
    logic [7:0] mem_reg [0:(1 << ADDR_W)-1];
    logic [PC_W-1:0] stack_reg [0:STACK_DEPTH-1];
    logic stack_ptr_reg;
    state_t state_reg;
    logic [1:0] clk_cnt_reg;
    logic extra_cycle_reg;
    logic [7:0] prescale_reg;
    logic [7:0] mem_rd_data_reg;
    logic [7:0] acc_reg;
    logic [PC_W-1:0] pc_reg;
    logic zero_reg;
    logic carry_reg;
    logic half_carry_reg;
    logic overflow_reg;
    logic pdf_reg;
    logic expiry_reg;
    logic irq_en_reg;
    logic [7:0] wdog_reg;

    op_t op;
    logic [7:0] operand;
    logic [7:0] result;
    logic write_mem;
    logic write_acc;
    logic touch_zero;
    logic carry_next;
    logic [PC_W-1:0] pc_next;
    logic pc_loaded;
    logic [7:0] bcd_result;
    logic bcd_carry;
    logic exec_fire;

    assign op = op_t'(instr_op);
    assign operand = mem_reg[instr_addr];
    // one instruction cycle is four system clocks; it executes on the last one
    assign exec_fire = (state_reg == ST_EXEC) && instr_valid && (clk_cnt_reg == 2'(CLKS_PER_CYCLE - 1));
    assign instr_ready = (state_reg == ST_EXEC) && (clk_cnt_reg == 2'(CLKS_PER_CYCLE - 1));

    bcd_adjuster u_bcd
    (
        .acc_in(acc_reg),
        .half_carry(half_carry_reg),
        .carry_in(carry_reg),
        .result(bcd_result),
        .carry_out(bcd_carry)
    );

    always_comb
    begin
        result = operand;
        write_mem = 1'b0;
        write_acc = 1'b0;
        touch_zero = 1'b0;
        carry_next = carry_reg;
        pc_next = pc_reg + 10'h001;
        pc_loaded = 1'b0;
        unique case (op)
            OP_INVERT_MEM:
            begin
                result = ~operand;
                write_mem = 1'b1;
                touch_zero = 1'b1;
            end
            OP_INVERT_TO_ACC:
            begin
                result = ~operand;
                write_acc = 1'b1;
                touch_zero = 1'b1;
            end
            OP_BCD_ADJUST:
            begin
                result = bcd_result;
                write_mem = 1'b1;
                carry_next = bcd_carry;
            end
            OP_MINUS_ONE_MEM, OP_MINUS_ONE_TO_ACC:
            begin
                result = operand - 8'h01;
                write_mem = (op == OP_MINUS_ONE_MEM);
                write_acc = (op == OP_MINUS_ONE_TO_ACC);
                touch_zero = 1'b1;
            end
            OP_PLUS_ONE_MEM, OP_PLUS_ONE_TO_ACC:
            begin
                result = operand + 8'h01;
                write_mem = (op == OP_PLUS_ONE_MEM);
                write_acc = (op == OP_PLUS_ONE_TO_ACC);
                touch_zero = 1'b1;
            end
            OP_POWER_DOWN:
            begin
                pc_next = pc_reg + 10'h001;
            end
            OP_DIRECT_BRANCH, OP_CALL:
            begin
                pc_next = instr_target;
                pc_loaded = 1'b1;
            end
            OP_COPY_MEM_TO_ACC:
            begin
                write_acc = 1'b1;
            end
            OP_COPY_ACC_TO_MEM:
            begin
                result = acc_reg;
                write_mem = 1'b1;
            end
            OP_COPY_IMM_TO_ACC:
            begin
                result = instr_imm;
                write_acc = 1'b1;
            end
            OP_DISJ_MEM_TO_ACC, OP_DISJUNCTION_TO_MEM:
            begin
                result = acc_reg | operand;
                write_acc = (op == OP_DISJ_MEM_TO_ACC);
                write_mem = (op == OP_DISJUNCTION_TO_MEM);
                touch_zero = 1'b1;
            end
            OP_DISJ_IMM_TO_ACC:
            begin
                result = acc_reg | instr_imm;
                write_acc = 1'b1;
                touch_zero = 1'b1;
            end
            OP_POP_PROGRAM_COUNTER, OP_INTERRUPT_EXIT:
            begin
                pc_next = stack_reg[stack_ptr_reg - 1'b1];
                pc_loaded = 1'b1;
            end
            OP_POP_WITH_CONST:
            begin
                pc_next = stack_reg[stack_ptr_reg - 1'b1];
                pc_loaded = 1'b1;
                result = instr_imm;
                write_acc = 1'b1;
            end
            OP_ROTATE_LEFT_MEM:
            begin
                result = {operand[6:0], operand[7]};
                write_mem = 1'b1;
            end
            OP_ROTATE_LEFT_TO_ACC:
            begin
                result = {operand[6:0], operand[7]};
                write_acc = 1'b1;
            end
            OP_ROTATE_LEFT_THROUGH_CARRY:
            begin
                result = {operand[6:0], carry_reg};
                carry_next = operand[7];
                write_mem = 1'b1;
            end
            OP_ROTATE_LEFT_CARRY_TO_ACC:
            begin
                result = {operand[6:0], carry_reg};
                carry_next = operand[7];
                write_acc = 1'b1;
            end
            OP_CLEAR_WATCHDOG:
            begin
            end
            OP_IDLE:
            begin
                pc_next = pc_reg + 10'h001;
            end
            default:
            begin
            end
        endcase
    end

    // sequencing: four clocks per cycle, one extra cycle after a program counter load
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            state_reg <= ST_EXEC;
            clk_cnt_reg <= 2'b00;
            extra_cycle_reg <= 1'b0;
        end
        else
        begin
            clk_cnt_reg <= (state_reg == ST_HALTED) ? 2'b00 : clk_cnt_reg + 2'b01;
            unique case (state_reg)
                ST_EXEC:
                begin
                    if (exec_fire && op == OP_POWER_DOWN)
                    begin
                        state_reg <= ST_HALTED;
                    end
                    else if (exec_fire && pc_loaded)
                    begin
                        state_reg <= ST_WAIT;
                    end
                end
                ST_WAIT:
                begin
                    if (clk_cnt_reg == 2'(CLKS_PER_CYCLE - 1))
                    begin
                        state_reg <= ST_EXEC;
                    end
                end
                ST_HALTED:
                begin
                    if (wake)
                    begin
                        state_reg <= ST_EXEC;
                    end
                end
                default:
                begin
                    state_reg <= ST_EXEC;
                end
            endcase
            extra_cycle_reg <= (state_reg == ST_WAIT);
        end
    end

    // data memory: holds its content across power down
    always_ff @(posedge sys_clk)
    begin
        if (exec_fire && write_mem)
        begin
            mem_reg[instr_addr] <= result;
        end
        else if (mem_wr_en)
        begin
            mem_reg[mem_wr_addr] <= mem_wr_data;
        end
        mem_rd_data_reg <= mem_reg[mem_rd_addr];
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            acc_reg <= ACC_RESET;
            pc_reg <= PC_RESET;
            stack_ptr_reg <= 1'b0;
        end
        else if (exec_fire)
        begin
            if (write_acc)
            begin
                acc_reg <= result;
            end
            pc_reg <= pc_next;
            if (op == OP_CALL)
            begin
                stack_reg[stack_ptr_reg] <= pc_reg + 10'h001;
                stack_ptr_reg <= stack_ptr_reg + 1'b1;
            end
            else if (op == OP_POP_PROGRAM_COUNTER || op == OP_POP_WITH_CONST || op == OP_INTERRUPT_EXIT)
            begin
                stack_ptr_reg <= stack_ptr_reg - 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            zero_reg <= 1'b0;
            carry_reg <= 1'b0;
            half_carry_reg <= 1'b0;
            overflow_reg <= 1'b0;
            irq_en_reg <= 1'b0;
        end
        else if (exec_fire)
        begin
            if (touch_zero)
            begin
                zero_reg <= (result == 8'h00);
            end
            carry_reg <= carry_next;
            if (op == OP_INTERRUPT_EXIT)
            begin
                irq_en_reg <= 1'b1;
            end
        end
    end

    // watchdog: a timeout arriving with a clear still lets the clear win, since the clear is checked before the tick
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            wdog_reg <= WDOG_RESET;
            prescale_reg <= PRESCALE_RESET;
            pdf_reg <= 1'b0;
            expiry_reg <= 1'b0;
        end
        else if (exec_fire && op == OP_POWER_DOWN)
        begin
            wdog_reg <= WDOG_RESET;
            prescale_reg <= PRESCALE_RESET;
            pdf_reg <= 1'b1;
            expiry_reg <= 1'b0;
        end
        else if (exec_fire && op == OP_CLEAR_WATCHDOG)
        begin
            wdog_reg <= WDOG_RESET;
            prescale_reg <= PRESCALE_RESET;
            pdf_reg <= 1'b0;
            expiry_reg <= 1'b0;
        end
        else if (wdog_tick)
        begin
            prescale_reg <= prescale_reg + 8'h01;
            if (prescale_reg == 8'hff)
            begin
                wdog_reg <= wdog_reg + 8'h01;
                if (wdog_reg == 8'hff)
                begin
                    expiry_reg <= 1'b1;
                end
            end
        end
    end

    assign mem_rd_data = mem_rd_data_reg;
    assign pc = pc_reg;
    assign acc = acc_reg;
    assign zero_flag = zero_reg;
    assign carry_flag = carry_reg;
    assign half_carry_flag = half_carry_reg;
    assign overflow_flag = overflow_reg;
    assign power_down_flag = pdf_reg;
    assign watchdog_expiry_flag = expiry_reg;
    assign global_irq_enable = irq_en_reg;
    assign clock_gated = (state_reg == ST_HALTED);
    assign watchdog_counter = wdog_reg;
endmodule

// ==== test/instr_exec_asserts.sv ====
// concurrent checks on the instruction execution core ports
`timescale 1ns/1ns
module instr_exec_asserts
    import exec_pkg::*;
(
    input wire logic sys_clk, // clock
    input wire logic sys_rst, // sync reset
    input wire logic instr_valid, // request
    input wire logic [4:0] instr_op, // op code
    input wire logic [7:0] instr_imm, // immediate
    input wire logic [PC_W-1:0] instr_target, // branch target
    input wire logic wake, // wake event
    input wire logic instr_ready, // take window
    input wire logic [PC_W-1:0] pc, // program counter
    input wire logic [7:0] acc, // accumulator
    input wire logic zero_flag, // zero
    input wire logic carry_flag, // carry
    input wire logic power_down_flag, // halt marker
    input wire logic watchdog_expiry_flag, // expiry
    input wire logic global_irq_enable, // irq enable
    input wire logic clock_gated, // halted
    input wire logic [7:0] watchdog_counter // watchdog count
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    logic take;
    logic load_op;
    assign take = instr_valid && instr_ready;
    assign load_op = instr_op inside {OP_DIRECT_BRANCH, OP_CALL, OP_POP_PROGRAM_COUNTER, OP_POP_WITH_CONST,
        OP_INTERRUPT_EXIT};
    // a pc load costs a whole extra four-clock cycle, so seven idle clocks before the next window
    sequence long_wait;
        !instr_ready [*7] ##1 instr_ready;
    endsequence
    sequence short_wait;
        !instr_ready [*3] ##1 instr_ready;
    endsequence
    chk_load_stall: assert property (take && load_op |=> long_wait)
        else $error("no extra cycle after program counter load");
    chk_idle_timing: assert property (take && instr_op == OP_IDLE |=> short_wait)
        else $error("idle instruction took the wrong time");
    chk_idle_pc: assert property (take && instr_op == OP_IDLE |=>
        pc == $past(pc) + 10'h001 && $stable(zero_flag) && $stable(carry_flag))
        else $error("idle did not just step the program counter");
    chk_branch_pc: assert property (take && instr_op == OP_DIRECT_BRANCH |=>
        pc == $past(instr_target) && $stable(zero_flag) && $stable(carry_flag))
        else $error("branch target or flags wrong");
    chk_copy_imm: assert property (take && instr_op == OP_COPY_IMM_TO_ACC |=>
        acc == $past(instr_imm) && $stable(zero_flag) && $stable(carry_flag))
        else $error("immediate copy wrong");
    chk_disj_imm: assert property (take && instr_op == OP_DISJ_IMM_TO_ACC |=>
        acc == ($past(acc) | $past(instr_imm)) && zero_flag == (acc == 8'h00) && $stable(carry_flag))
        else $error("immediate disjunction wrong");
    chk_pop_const: assert property (take && instr_op == OP_POP_WITH_CONST |=>
        acc == $past(instr_imm) && $stable(zero_flag) && $stable(carry_flag))
        else $error("return with constant wrong");
    chk_irq_exit: assert property (take && instr_op == OP_INTERRUPT_EXIT |=> global_irq_enable)
        else $error("interrupt exit left interrupts off");
    chk_halt_entry: assert property (take && instr_op == OP_POWER_DOWN |=> power_down_flag &&
        !watchdog_expiry_flag && watchdog_counter == 8'h00 && clock_gated && pc == $past(pc) + 10'h001)
        else $error("power down entry state wrong");
    chk_halt_hold: assert property (clock_gated && !wake |-> !instr_ready)
        else $error("instruction window open while halted");
    chk_halt_keep: assert property (clock_gated && $past(clock_gated) |-> $stable(acc) && $stable(pc))
        else $error("state changed while halted");
endmodule

bind instr_exec instr_exec_asserts u_asserts (.sys_clk, .sys_rst, .instr_valid, .instr_op, .instr_imm,
    .instr_target, .wake, .instr_ready, .pc, .acc, .zero_flag, .carry_flag, .power_down_flag,
    .watchdog_expiry_flag, .global_irq_enable, .clock_gated, .watchdog_counter);

// ==== test/instr_exec_tb.sv ====
// self-checking bench for the instruction execution core
`timescale 1ns/1ns
module instr_exec_tb
    import exec_pkg::*;
;
    typedef struct packed {op_t op; logic [7:0] imm, mem_in, mem_out, acc_out; logic z, c;} step_t;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic instr_valid = 1'b0;
    logic [4:0] instr_op = 5'h00;
    logic [ADDR_W-1:0] instr_addr = 6'h00;
    logic [7:0] instr_imm = 8'h00;
    logic [PC_W-1:0] instr_target = 10'h000;
    logic wake = 1'b0;
    logic wdog_tick = 1'b0;
    logic mem_wr_en = 1'b0;
    logic [ADDR_W-1:0] mem_wr_addr = 6'h00;
    logic [7:0] mem_wr_data = 8'h00;
    logic [ADDR_W-1:0] mem_rd_addr = 6'h00;
    logic [7:0] mem_rd_data, acc, watchdog_counter;
    logic [PC_W-1:0] pc;
    logic instr_ready, zero_flag, carry_flag, half_carry_flag, overflow_flag;
    logic power_down_flag, watchdog_expiry_flag, global_irq_enable, clock_gated;
    int err_count = 0;
    int samples_checked = 0;
    int gap = 0;
    time t_last = 0;
    // flags carry over from row to row, so each row expects what the previous rows left
    step_t steps [26] = '{
        '{OP_INVERT_MEM, 8'h00, 8'hff, 8'h00, 8'h00, 1'b1, 1'b0},
        '{OP_INVERT_TO_ACC, 8'h00, 8'h5a, 8'h5a, 8'ha5, 1'b0, 1'b0},
        '{OP_MINUS_ONE_MEM, 8'h00, 8'h01, 8'h00, 8'ha5, 1'b1, 1'b0},
        '{OP_MINUS_ONE_TO_ACC, 8'h00, 8'h00, 8'h00, 8'hff, 1'b0, 1'b0},
        '{OP_PLUS_ONE_MEM, 8'h00, 8'hff, 8'h00, 8'hff, 1'b1, 1'b0},
        '{OP_PLUS_ONE_TO_ACC, 8'h00, 8'h7f, 8'h7f, 8'h80, 1'b0, 1'b0},
        '{OP_COPY_MEM_TO_ACC, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0},
        '{OP_COPY_IMM_TO_ACC, 8'h3c, 8'h11, 8'h11, 8'h3c, 1'b0, 1'b0},
        '{OP_COPY_ACC_TO_MEM, 8'h00, 8'h11, 8'h3c, 8'h3c, 1'b0, 1'b0},
        '{OP_DISJ_MEM_TO_ACC, 8'h00, 8'h41, 8'h41, 8'h7d, 1'b0, 1'b0},
        '{OP_DISJUNCTION_TO_MEM, 8'h00, 8'h82, 8'hff, 8'h7d, 1'b0, 1'b0},
        '{OP_COPY_IMM_TO_ACC, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0},
        '{OP_DISJ_IMM_TO_ACC, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0},
        '{OP_ROTATE_LEFT_MEM, 8'h00, 8'h81, 8'h03, 8'h00, 1'b1, 1'b0},
        '{OP_ROTATE_LEFT_TO_ACC, 8'h00, 8'hc0, 8'hc0, 8'h81, 1'b1, 1'b0},
        '{OP_ROTATE_LEFT_THROUGH_CARRY, 8'h00, 8'h80, 8'h00, 8'h81, 1'b1, 1'b1},
        '{OP_ROTATE_LEFT_CARRY_TO_ACC, 8'h00, 8'h40, 8'h40, 8'h81, 1'b1, 1'b0},
        '{OP_COPY_IMM_TO_ACC, 8'h9a, 8'h00, 8'h00, 8'h9a, 1'b1, 1'b0},
        '{OP_BCD_ADJUST, 8'h00, 8'h77, 8'h00, 8'h9a, 1'b1, 1'b1},
        '{OP_COPY_IMM_TO_ACC, 8'h45, 8'h00, 8'h00, 8'h45, 1'b1, 1'b1},
        '{OP_BCD_ADJUST, 8'h00, 8'h77, 8'ha5, 8'h45, 1'b1, 1'b1},
        '{OP_ROTATE_LEFT_CARRY_TO_ACC, 8'h00, 8'h3f, 8'h3f, 8'h7f, 1'b1, 1'b0},
        '{OP_COPY_IMM_TO_ACC, 8'h99, 8'h00, 8'h00, 8'h99, 1'b1, 1'b0},
        '{OP_BCD_ADJUST, 8'h00, 8'h77, 8'h99, 8'h99, 1'b1, 1'b0},
        '{OP_COPY_IMM_TO_ACC, 8'ha3, 8'h00, 8'h00, 8'ha3, 1'b1, 1'b0},
        '{OP_BCD_ADJUST, 8'h00, 8'h77, 8'h03, 8'ha3, 1'b1, 1'b1}
    };

    instr_exec DUT (.sys_clk, .sys_rst, .instr_valid, .instr_op, .instr_addr, .instr_imm, .instr_target, .wake,
        .wdog_tick, .mem_wr_en, .mem_wr_addr, .mem_wr_data, .mem_rd_addr, .mem_rd_data, .instr_ready, .pc, .acc,
        .zero_flag, .carry_flag, .half_carry_flag, .overflow_flag, .power_down_flag, .watchdog_expiry_flag,
        .global_irq_enable, .clock_gated, .watchdog_counter);

    initial
    begin
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic stop_test();
        $display("mismatches %0d, checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [9:0] got, input logic [9:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // ready is combinational from the phase counter, so it is sampled on the falling edge
    task automatic run(input op_t op, input logic [7:0] imm, input logic [9:0] tgt);
        int n;
        @(posedge sys_clk);
        instr_op <= op;
        instr_addr <= 6'h05;
        instr_imm <= imm;
        instr_target <= tgt;
        instr_valid <= 1'b1;
        n = 0;
        @(negedge sys_clk);
        while (instr_ready !== 1'b1 && n < 40)
        begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 40)
        begin
            err_count++;
            stop_test();
        end
        @(posedge sys_clk);
        gap = int'(($time - t_last) / 100);
        t_last = $time;
        instr_valid <= 1'b0;
        @(negedge sys_clk);
    endtask

    task automatic mem_put(input logic [7:0] d);
        @(posedge sys_clk);
        mem_wr_en <= 1'b1;
        mem_wr_addr <= 6'h05;
        mem_wr_data <= d;
        @(posedge sys_clk);
        mem_wr_en <= 1'b0;
    endtask

    task automatic mem_chk(input logic [7:0] exp);
        @(posedge sys_clk);
        mem_rd_addr <= 6'h05;
        @(posedge sys_clk);
        @(negedge sys_clk);
        check(10'(mem_rd_data), 10'(exp));
    endtask

    initial
    begin
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(negedge sys_clk);
        check(10'(acc), 10'h000);
        check(10'(global_irq_enable), 10'h000);
        foreach (steps[i])
        begin
            mem_put(steps[i].mem_in);
            run(steps[i].op, steps[i].imm, 10'h000);
            check(10'(acc), 10'(steps[i].acc_out));
            check(10'(zero_flag), 10'(steps[i].z));
            check(10'(carry_flag), 10'(steps[i].c));
            check(10'({half_carry_flag, overflow_flag}), 10'h000);
            mem_chk(steps[i].mem_out);
        end
        run(OP_DIRECT_BRANCH, 8'h00, 10'h155);
        check(pc, 10'h155);
        check(10'({zero_flag, carry_flag}), 10'h003);
        run(OP_IDLE, 8'h00, 10'h000);
        check(10'(gap), 10'h008);
        run(OP_IDLE, 8'h00, 10'h000);
        check(10'(gap), 10'h004);
        check(pc, 10'h157);
        run(OP_CALL, 8'h00, 10'h020);
        run(OP_POP_PROGRAM_COUNTER, 8'h00, 10'h000);
        check(pc, 10'h158);
        run(OP_IDLE, 8'h00, 10'h000);
        check(10'(gap), 10'h008);
        run(OP_CALL, 8'h00, 10'h3ff);
        run(OP_POP_WITH_CONST, 8'h6e, 10'h000);
        check(pc, 10'h15a);
        check(10'(acc), 10'h06e);
        run(OP_CALL, 8'h00, 10'h200);
        run(OP_INTERRUPT_EXIT, 8'h00, 10'h000);
        check(pc, 10'h15b);
        check(10'(global_irq_enable), 10'h001);
        // 257 prescaler wraps: the watchdog overflows once, raising expiry, then counts on to one
        @(posedge sys_clk);
        wdog_tick <= 1'b1;
        repeat (65792) @(posedge sys_clk);
        wdog_tick <= 1'b0;
        @(negedge sys_clk);
        check(10'(watchdog_counter != 8'h00), 10'h001);
        check(10'({watchdog_expiry_flag, watchdog_counter}), 10'h101);
        run(OP_POWER_DOWN, 8'h00, 10'h000);
        check(10'(watchdog_counter), 10'h000);
        check(10'({power_down_flag, watchdog_expiry_flag, clock_gated}), 10'h005);
        repeat (12)
        begin
            @(negedge sys_clk);
            check(10'(instr_ready), 10'h000);
        end
        check(pc, 10'h15c);
        @(posedge sys_clk);
        wake <= 1'b1;
        @(posedge sys_clk);
        wake <= 1'b0;
        run(OP_IDLE, 8'h00, 10'h000);
        check(pc, 10'h15d);
        check(10'({clock_gated, acc}), 10'h06e);
        run(OP_CLEAR_WATCHDOG, 8'h00, 10'h000);
        check(10'({power_down_flag, watchdog_expiry_flag, watchdog_counter}), 10'h000);
        stop_test();
    end
endmodule
